// file: iepc_regs.svh
`ifndef IEPC_REGS_SVH
`define IEPC_REGS_SVH
// register offsets on the plain port
`define IEPC_OFS_ENABLE      4'h0
`define IEPC_OFS_PRIORITY    4'h1
`define IEPC_OFS_TIMER_IRQ_CONTROL_REG        4'h2
`define IEPC_OFS_GATE        4'h3
`define IEPC_OFS_STATUS      4'h4
`define IEPC_OFS_EV_CLEAR    4'h5
`define IEPC_OFS_EV_ENABLE   4'h6
// enable / priority bit positions
`define IEPC_BIT_EXT0        0
`define IEPC_BIT_TMR0        1
`define IEPC_BIT_EXT1        2
`define IEPC_BIT_TMR1        3
`define IEPC_BIT_SER         4
`define IEPC_BIT_TMR2        5
`define IEPC_BIT_GLOBAL      7
// control register bit positions
`define IEPC_TC_EXT0_TYPE    0
`define IEPC_TC_EXT0_FLAG    1
`define IEPC_TC_EXT1_TYPE    2
`define IEPC_TC_EXT1_FLAG    3
`define IEPC_TC_TMR0_RUN     4
`define IEPC_TC_TMR0_FLAG    5
`define IEPC_TC_TMR1_RUN     6
`define IEPC_TC_TMR1_FLAG    7
// writable masks; reserved bits read zero
`define IEPC_ENABLE_MASK     8'hbf
`define IEPC_PRIORITY_MASK   8'h3f
`define IEPC_RESET_VALUE     8'h00
// vector addresses
`define IEPC_VEC_EXT0        16'h0003
`define IEPC_VEC_TMR0        16'h000b
`define IEPC_VEC_EXT1        16'h0013
`define IEPC_VEC_TMR1        16'h001b
`define IEPC_VEC_SER         16'h0023
`define IEPC_VEC_TMR2        16'h002b
`define IEPC_NUM_SRC         6
`endif

// file: iepc_pkg.sv
package iepc_pkg;
    typedef enum logic [2:0] {
        IEPC_ST_IDLE = 3'b001,
        IEPC_ST_LOW  = 3'b010,
        IEPC_ST_HIGH = 3'b100
    } iepc_level_type;
endpackage

// file: iepc_ctrl.sv
`timescale 1ns/10ps
`include "iepc_regs.svh"
module iepc_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        ext0_request_pin,
    input  wire logic        ext1_request_pin,
    input  wire logic        timer0_overflow,
    input  wire logic        timer1_overflow,
    input  wire logic        uart_rx_done_flag,
    input  wire logic        uart_tx_done_flag,
    input  wire logic        timer2_overflow_flag,
    input  wire logic        timer2_ext_flag,
    input  wire logic        core_ack,
    input  wire logic        core_reti,
    output logic             irq_req,
    output logic      [15:0] irq_vector,
    output logic             timer0_count_en,
    output logic             timer1_count_en,
    output logic             irq
);
    import iepc_pkg::*;

    logic [7:0]  irq_enable_reg;
    logic [7:0]  irq_priority_reg;
    logic [7:0]  timer_irq_control_reg;
    logic [1:0]  gate_reg;
    logic [2:0]  ev_status;
    logic [2:0]  ev_enable;
    logic        ext0_pin_q;
    logic        ext1_pin_q;
    logic        in_service_low;
    logic        in_service_high;
    iepc_level_type level_state;
    logic [5:0]  src_req;
    logic [5:0]  src_ok;
    logic [5:0]  high_req;
    logic [5:0]  low_req;
    logic [5:0]  pick;
    logic        pick_high;
    logic        grant;
    logic [15:0] next_vector;
    logic        ext0_fall;
    logic        ext1_fall;
    logic        wr_timer_irq_control_reg;

    assign wr_timer_irq_control_reg = wr && addr == `IEPC_OFS_TIMER_IRQ_CONTROL_REG;
    assign ext0_fall = ext0_pin_q && !ext0_request_pin;
    assign ext1_fall = ext1_pin_q && !ext1_request_pin;

    // level-triggered inputs request straight from the pin, no latch
    always_comb
    begin
        src_req[`IEPC_BIT_EXT0] = timer_irq_control_reg[`IEPC_TC_EXT0_TYPE] ?
            timer_irq_control_reg[`IEPC_TC_EXT0_FLAG] : !ext0_request_pin;
        src_req[`IEPC_BIT_TMR0] = timer_irq_control_reg[`IEPC_TC_TMR0_FLAG];
        src_req[`IEPC_BIT_EXT1] = timer_irq_control_reg[`IEPC_TC_EXT1_TYPE] ?
            timer_irq_control_reg[`IEPC_TC_EXT1_FLAG] : !ext1_request_pin;
        src_req[`IEPC_BIT_TMR1] = timer_irq_control_reg[`IEPC_TC_TMR1_FLAG];
        src_req[`IEPC_BIT_SER]  = uart_rx_done_flag || uart_tx_done_flag;
        src_req[`IEPC_BIT_TMR2] = timer2_overflow_flag || timer2_ext_flag;
    end

    assign src_ok   = src_req & irq_enable_reg[5:0]
                    & {6{irq_enable_reg[`IEPC_BIT_GLOBAL]}};
    assign high_req = src_ok & irq_priority_reg[5:0];
    assign low_req  = src_ok & ~irq_priority_reg[5:0];

    // lowest bit index wins within a level
    always_comb
    begin
        pick_high = 1'b0;
        pick      = 6'h00;
        if (|high_req && !in_service_high)
        begin
            pick_high = 1'b1;
            pick      = high_req & (~high_req + 6'h01);
        end
        else if (|low_req && !in_service_high && !in_service_low)
        begin
            pick = low_req & (~low_req + 6'h01);
        end
    end
    assign grant = |pick;

    always_comb
    begin
        case (pick)
            6'h01:   next_vector = `IEPC_VEC_EXT0;
            6'h02:   next_vector = `IEPC_VEC_TMR0;
            6'h04:   next_vector = `IEPC_VEC_EXT1;
            6'h08:   next_vector = `IEPC_VEC_TMR1;
            6'h10:   next_vector = `IEPC_VEC_SER;
            6'h20:   next_vector = `IEPC_VEC_TMR2;
            default: next_vector = 16'h0000;
        endcase
    end

    // request held stable while the core finishes taking it
    logic [5:0] held_src;
    logic       held_high;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_req    <= 1'b0;
            irq_vector <= 16'h0000;
            held_src   <= 6'h00;
            held_high  <= 1'b0;
        end
        else if (irq_req && core_ack)
        begin
            irq_req  <= 1'b0;
            held_src <= 6'h00;
        end
        else if (!irq_req && grant)
        begin
            irq_req    <= 1'b1;
            irq_vector <= next_vector;
            held_src   <= pick;
            held_high  <= pick_high;
        end
        else if (irq_req && !(|(held_src & src_ok)))
        begin
            // source withdrawn or masked before it was taken, so no late acknowledge
            irq_req  <= 1'b0;
            held_src <= 6'h00;
        end
    end

    logic took;
    assign took = irq_req && core_ack;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            in_service_low  <= 1'b0;
            in_service_high <= 1'b0;
            level_state     <= IEPC_ST_IDLE;
        end
        else
        begin
            case (level_state)
                IEPC_ST_IDLE:
                    if (took)
                    begin
                        level_state <= held_high ? IEPC_ST_HIGH : IEPC_ST_LOW;
                    end
                IEPC_ST_LOW:
                    if (took && held_high)
                    begin
                        level_state <= IEPC_ST_HIGH;
                    end
                    else if (core_reti)
                    begin
                        level_state <= IEPC_ST_IDLE;
                    end
                IEPC_ST_HIGH:
                    if (core_reti)
                    begin
                        level_state <= in_service_low ? IEPC_ST_LOW : IEPC_ST_IDLE;
                    end
                default: level_state <= IEPC_ST_IDLE;
            endcase
            // return closes the innermost level first
            if (took && held_high)
            begin
                in_service_high <= 1'b1;
            end
            else if (core_reti && in_service_high)
            begin
                in_service_high <= 1'b0;
            end
            if (took && !held_high)
            begin
                in_service_low <= 1'b1;
            end
            else if (core_reti && !in_service_high)
            begin
                in_service_low <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ext0_pin_q <= 1'b1;
            ext1_pin_q <= 1'b1;
        end
        else
        begin
            ext0_pin_q <= ext0_request_pin;
            ext1_pin_q <= ext1_request_pin;
        end
    end

    // hardware set wins over software write and vector clear
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            timer_irq_control_reg <= `IEPC_RESET_VALUE;
        end
        else
        begin
            if (wr_timer_irq_control_reg)
            begin
                timer_irq_control_reg <= wdata;
            end
            if (took && held_src[`IEPC_BIT_TMR0])
                timer_irq_control_reg[`IEPC_TC_TMR0_FLAG] <= 1'b0;
            if (took && held_src[`IEPC_BIT_TMR1])
                timer_irq_control_reg[`IEPC_TC_TMR1_FLAG] <= 1'b0;
            if (took && held_src[`IEPC_BIT_EXT0])
                timer_irq_control_reg[`IEPC_TC_EXT0_FLAG] <= 1'b0;
            if (took && held_src[`IEPC_BIT_EXT1])
                timer_irq_control_reg[`IEPC_TC_EXT1_FLAG] <= 1'b0;
            if (timer0_overflow)
            begin
                timer_irq_control_reg[`IEPC_TC_TMR0_FLAG] <= 1'b1;
            end
            if (timer1_overflow)
            begin
                timer_irq_control_reg[`IEPC_TC_TMR1_FLAG] <= 1'b1;
            end
            if (ext0_fall && timer_irq_control_reg[`IEPC_TC_EXT0_TYPE])
            begin
                timer_irq_control_reg[`IEPC_TC_EXT0_FLAG] <= 1'b1;
            end
            if (ext1_fall && timer_irq_control_reg[`IEPC_TC_EXT1_TYPE])
            begin
                timer_irq_control_reg[`IEPC_TC_EXT1_FLAG] <= 1'b1;
            end
        end
    end

    // reserved bits stored as zero, so a stray one does nothing
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irq_enable_reg   <= `IEPC_RESET_VALUE;
            irq_priority_reg <= `IEPC_RESET_VALUE;
            gate_reg         <= 2'h0;
            ev_enable        <= 3'h0;
        end
        else if (wr)
        begin
            case (addr)
                `IEPC_OFS_ENABLE:    irq_enable_reg   <= wdata & `IEPC_ENABLE_MASK;
                `IEPC_OFS_PRIORITY:  irq_priority_reg <= wdata & `IEPC_PRIORITY_MASK;
                `IEPC_OFS_GATE:      gate_reg         <= wdata[1:0];
                `IEPC_OFS_EV_ENABLE: ev_enable        <= wdata[2:0];
                default:             ;
            endcase
        end
    end

    // events: grant taken, nested high grant, return from service
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ev_status <= 3'h0;
        end
        else
        begin
            ev_status <= (ev_status & ~((wr && addr == `IEPC_OFS_EV_CLEAR) ? wdata[2:0] : 3'h0))
                       | {core_reti, took && in_service_low && held_high, took};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            timer0_count_en <= 1'b0;
            timer1_count_en <= 1'b0;
            irq             <= 1'b0;
        end
        else
        begin
            timer0_count_en <= timer_irq_control_reg[`IEPC_TC_TMR0_RUN]
                               && (!gate_reg[0] || ext0_request_pin);
            timer1_count_en <= timer_irq_control_reg[`IEPC_TC_TMR1_RUN]
                               && (!gate_reg[1] || ext1_request_pin);
            irq             <= |(ev_status & ev_enable);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst || !rd)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            case (addr)
                `IEPC_OFS_ENABLE:    rdata <= irq_enable_reg;
                `IEPC_OFS_PRIORITY:  rdata <= irq_priority_reg;
                `IEPC_OFS_TIMER_IRQ_CONTROL_REG:      rdata <= timer_irq_control_reg;
                `IEPC_OFS_GATE:      rdata <= {6'h00, gate_reg};
                `IEPC_OFS_STATUS:    rdata <= {3'h0, in_service_high, in_service_low, ev_status};
                `IEPC_OFS_EV_ENABLE: rdata <= {5'h00, ev_enable};
                default:             rdata <= 8'h00;
            endcase
        end
    end

    chk_global_blocks: assert property (@(posedge mclk) disable iff (rst)
        !irq_enable_reg[`IEPC_BIT_GLOBAL] |=> !(irq_req && !$past(irq_req)))
        else $error("request raised with global enable clear");
    chk_no_nest_same: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_req) |-> $past(level_state) == IEPC_ST_IDLE || (held_high && $past(level_state) == IEPC_ST_LOW))
        else $error("request raised over a level already in service");
    chk_vector_map: assert property (@(posedge mclk) disable iff (rst)
        $rose(irq_req) && held_src == 6'h01 |-> irq_vector == `IEPC_VEC_EXT0)
        else $error("external 0 vector wrong");
    chk_order_first: assert property (@(posedge mclk) disable iff (rst)
        !irq_req && grant && src_ok[0] && !irq_priority_reg[0] && !(|high_req) |=> held_src == 6'h01)
        else $error("external 0 not chosen first");
    chk_tmr_flag_clr: assert property (@(posedge mclk) disable iff (rst)
        took && held_src == 6'h02 && !timer0_overflow && !wr_timer_irq_control_reg |=> !timer_irq_control_reg[5])
        else $error("timer 0 flag not cleared on vector");
    chk_edge_sets: assert property (@(posedge mclk) disable iff (rst)
        ext1_fall && timer_irq_control_reg[2] && !wr_timer_irq_control_reg |=> timer_irq_control_reg[3])
        else $error("external 1 edge lost");
    chk_gate_count: assert property (@(posedge mclk) disable iff (rst)
        gate_reg[0] && !ext0_request_pin |=> !timer0_count_en)
        else $error("gated timer 0 counted with pin low");
    chk_service_flag: assert property (@(posedge mclk) disable iff (rst)
        took && !held_high |=> in_service_low)
        else $error("low in-service flag not set");
    cov_high_nest: cover property (@(posedge mclk) disable iff (rst) took && in_service_low && held_high);
    cov_return: cover property (@(posedge mclk) disable iff (rst) core_reti && in_service_high);
    cov_two_pending: cover property (@(posedge mclk) disable iff (rst) $countones(low_req) > 1 && grant);
endmodule // iepc_ctrl

// file: iepc_core_model.sv
`timescale 1ns/10ps
module iepc_core_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic [7:0]  ack_delay,
    input  wire logic [7:0]  svc_len,
    output logic             core_ack,
    output logic             core_reti
);
    logic [15:0] log_q[$];
    int          depth;
    int          wait_cnt;
    int          left[0:3];

    initial
    begin
        core_ack  = 1'b0;
        core_reti = 1'b0;
        depth     = 0;
        wait_cnt  = 0;
    end

    // only the innermost routine runs; an outer one is frozen while nested
    always @(posedge mclk)
    begin
        core_ack  <= 1'b0;
        core_reti <= 1'b0;
        if (rst)
        begin
            depth    = 0;
            wait_cnt = 0;
        end
        else if (depth > 0 && left[depth] == 0)
        begin
            core_reti <= 1'b1;
            depth = depth - 1;
        end
        else
        begin
            if (depth > 0)
                left[depth] = left[depth] - 1;
            // ack pulse still visible here, so no double take
            if (irq_req === 1'b1 && !core_ack)
            begin
                if (wait_cnt >= ack_delay)
                begin
                    core_ack <= 1'b1;
                    log_q.push_back(irq_vector);
                    depth = depth + 1;
                    left[depth] = svc_len;
                    wait_cnt = 0;
                end
                else
                    wait_cnt = wait_cnt + 1;
            end
            else
                wait_cnt = 0;
        end
    end
endmodule // iepc_core_model

// file: interrupt_enable_priority_control_test.sv
`timescale 1ns/10ps
`include "iepc_regs.svh"
module interrupt_enable_priority_control_test;
    logic        mclk = 0, rst = 1, wr = 0, rd = 0;
    logic [3:0]  addr = 0;
    logic [7:0]  wdata = 0, rdata, d, ack_delay = 0, svc_len = 4;
    logic        ext0_request_pin = 1, ext1_request_pin = 1, timer0_overflow = 0, timer1_overflow = 0;
    logic        uart_rx_done_flag = 0, uart_tx_done_flag = 0, timer2_overflow_flag = 0, timer2_ext_flag = 0;
    logic        core_ack, core_reti, irq_req, timer0_count_en, timer1_count_en, irq;
    logic [15:0] irq_vector;
    logic [15:0] vecs[6] = '{`IEPC_VEC_EXT0, `IEPC_VEC_TMR0, `IEPC_VEC_EXT1, `IEPC_VEC_TMR1,
                             `IEPC_VEC_SER, `IEPC_VEC_TMR2};
    int          miscompares = 0, total_checks = 0;

    iepc_ctrl u_dut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .ext0_request_pin, .ext1_request_pin,
        .timer0_overflow, .timer1_overflow, .uart_rx_done_flag, .uart_tx_done_flag, .timer2_overflow_flag,
        .timer2_ext_flag, .core_ack, .core_reti, .irq_req, .irq_vector, .timer0_count_en, .timer1_count_en, .irq);
    iepc_core_model u_core (.mclk, .rst, .irq_req, .irq_vector, .ack_delay, .svc_len, .core_ack, .core_reti);

    always #50 mclk = ~mclk;

    // level sources are cleared by the service routine, as software would
    always @(posedge mclk)
        if (core_ack === 1'b1 && irq_vector === `IEPC_VEC_SER)
            {uart_rx_done_flag, uart_tx_done_flag} <= 2'b00;
        else if (core_ack === 1'b1 && irq_vector === `IEPC_VEC_TMR2)
            {timer2_overflow_flag, timer2_ext_flag} <= 2'b00;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic pop_vec(input logic [15:0] exp);
        logic [15:0] got;
        got = (u_core.log_q.size() > 0) ? u_core.log_q.pop_front() : 16'hffff;
        check("vector", got, exp);
    endtask

    // quiet for four cycles, since a re-pick follows each return by two cycles
    task automatic settle;
        int q;
        q = 0;
        for (int n = 0; n < 600 && q < 4; n++)
        begin
            @(posedge mclk);
            q = (irq_req === 1'b0 && u_core.depth == 0) ? q + 1 : 0;
        end
        check("settle", q, 4);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_of_test;
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++)
            if (a != 5)
            begin
                reg_read(a[3:0], d);
                check("reset read", d, 8'h00);
            end
        reg_write(`IEPC_OFS_ENABLE, 8'hff);
        reg_read(`IEPC_OFS_ENABLE, d);
        check("enable reserved", d, `IEPC_ENABLE_MASK);
        reg_write(`IEPC_OFS_PRIORITY, 8'hff);
        reg_read(`IEPC_OFS_PRIORITY, d);
        check("priority reserved", d, `IEPC_PRIORITY_MASK);
        reg_write(`IEPC_OFS_PRIORITY, 8'h00);
        // timer0 flag, global gate, event status and level output
        reg_write(`IEPC_OFS_EV_ENABLE, 8'h01);
        reg_write(`IEPC_OFS_ENABLE, 8'h02);
        @(posedge mclk) timer0_overflow <= 1'b1;
        @(posedge mclk) timer0_overflow <= 1'b0;
        repeat (4) @(posedge mclk);
        check("req global off", irq_req, 1'b0);
        reg_read(`IEPC_OFS_TIMER_IRQ_CONTROL_REG, d);
        check("timer0 flag set", d, 8'h20);
        reg_write(`IEPC_OFS_ENABLE, 8'h82);
        settle;
        pop_vec(`IEPC_VEC_TMR0);
        reg_read(`IEPC_OFS_TIMER_IRQ_CONTROL_REG, d);
        check("timer0 flag clear", d, 8'h00);
        check("irq on", irq, 1'b1);
        reg_read(`IEPC_OFS_STATUS, d);
        check("grant status", d & 8'h01, 8'h01);
        reg_write(`IEPC_OFS_EV_CLEAR, 8'h07);
        repeat (2) @(posedge mclk);
        check("irq cleared", irq, 1'b0);
        // from here only a nested high grant may raise irq
        reg_write(`IEPC_OFS_EV_ENABLE, 8'h02);
        // per-source enable: only timer2 admitted, serial waits
        reg_write(`IEPC_OFS_ENABLE, 8'ha0);
        @(posedge mclk) {uart_tx_done_flag, timer2_ext_flag} <= 2'b11;
        settle;
        pop_vec(`IEPC_VEC_TMR2);
        check("serial held", u_core.log_q.size(), 0);
        reg_write(`IEPC_OFS_ENABLE, 8'h90);
        settle;
        pop_vec(`IEPC_VEC_SER);
        // all six at once, each source raised to high level in turn, then none
        reg_write(`IEPC_OFS_TIMER_IRQ_CONTROL_REG, 8'h05);
        ack_delay <= 8'h03;
        for (int i = 0; i < 7; i++)
        begin
            reg_write(`IEPC_OFS_ENABLE, 8'h3f);
            reg_write(`IEPC_OFS_PRIORITY, (i < 6) ? (8'h01 << i) : 8'h00);
            @(posedge mclk);
            {ext0_request_pin, ext1_request_pin} <= 2'b00;
            {timer0_overflow, timer1_overflow, uart_rx_done_flag, timer2_overflow_flag} <= 4'hf;
            @(posedge mclk) {timer0_overflow, timer1_overflow} <= 2'b00;
            repeat (4) @(posedge mclk);
            check("req global off", irq_req, 1'b0);
            reg_write(`IEPC_OFS_ENABLE, 8'hbf);
            settle;
            if (i < 6)
                pop_vec(vecs[i]);
            for (int j = 0; j < 6; j++)
                if (j != i)
                    pop_vec(vecs[j]);
            check("no extra", u_core.log_q.size(), 0);
            check("irq masked", irq, 1'b0);
            {ext0_request_pin, ext1_request_pin} <= 2'b11;
        end
        // nesting: low timer0 in service, low ext0 waits, high timer1 nests
        ack_delay <= 8'h00;
        svc_len <= 8'd40;
        reg_write(`IEPC_OFS_PRIORITY, 8'h08);
        @(posedge mclk) timer0_overflow <= 1'b1;
        @(posedge mclk) timer0_overflow <= 1'b0;
        repeat (4) @(posedge mclk);
        ext0_request_pin <= 1'b0;
        repeat (6) @(posedge mclk);
        check("no same level nest", irq_req, 1'b0);
        timer1_overflow <= 1'b1;
        @(posedge mclk) timer1_overflow <= 1'b0;
        settle;
        pop_vec(`IEPC_VEC_TMR0);
        pop_vec(`IEPC_VEC_TMR1);
        pop_vec(`IEPC_VEC_EXT0);
        check("irq nested", irq, 1'b1);
        ext0_request_pin <= 1'b1;
        // level mode: both pins held low, only external 0 enabled, asks again after each return
        svc_len <= 8'd4;
        reg_write(`IEPC_OFS_TIMER_IRQ_CONTROL_REG, 8'h00);
        reg_write(`IEPC_OFS_ENABLE, 8'h81);
        @(posedge mclk) {ext0_request_pin, ext1_request_pin} <= 2'b00;
        for (int n = 0; n < 200 && u_core.log_q.size() < 2; n++)
            @(posedge mclk);
        {ext0_request_pin, ext1_request_pin} <= 2'b11;
        settle;
        pop_vec(`IEPC_VEC_EXT0);
        pop_vec(`IEPC_VEC_EXT0);
        check("level count", u_core.log_q.size(), 0);
        // run and gate of both timers
        reg_write(`IEPC_OFS_ENABLE, 8'h00);
        reg_write(`IEPC_OFS_TIMER_IRQ_CONTROL_REG, 8'h50);
        repeat (3) @(posedge mclk);
        check("t0 run", timer0_count_en, 1'b1);
        check("t1 run", timer1_count_en, 1'b1);
        reg_write(`IEPC_OFS_GATE, 8'h03);
        ext0_request_pin <= 1'b0;
        repeat (3) @(posedge mclk);
        check("t0 gated", timer0_count_en, 1'b0);
        check("t1 pin high", timer1_count_en, 1'b1);
        ext0_request_pin <= 1'b1;
        reg_write(`IEPC_OFS_TIMER_IRQ_CONTROL_REG, 8'h00);
        repeat (3) @(posedge mclk);
        check("t0 stop", timer0_count_en, 1'b0);
        check("t1 stop", timer1_count_en, 1'b0);
        end_of_test;
    end
endmodule // interrupt_enable_priority_control_test
